/* File: logic/ccp_pkg.sv */
// Purpose: shared constants and state types of the capture/compare/pwm block
// Assumes: classic wishbone, 32-bit data, registers in byte lane 0
// Notes: one word per register, bits above 7 read as zero
package ccp_pkg;

  // number of capture/compare/pwm units
  localparam int NUM_UNITS = 4;

  // register byte offsets inside one unit window
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CAPSEL = 8'h04;
  localparam logic [7:0] OFF_LOW = 8'h08;
  localparam logic [7:0] OFF_HIGH = 8'h0C;
  // distance between unit windows
  localparam logic [7:0] UNIT_STRIDE = 8'h10;
  // shared timer choice register
  localparam logic [7:0] OFF_TMAP = 8'h40;

  // control field positions
  localparam int BIT_ON = 7;
  localparam int BIT_OUT = 5;
  localparam int BIT_FMT = 4;

  // function select codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TGL_CLR = 4'h1;
  localparam logic [3:0] MODE_TGL = 4'h2;
  localparam logic [3:0] MODE_CAP_ANY = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4 = 4'h6;
  localparam logic [3:0] MODE_CAP_16 = 4'h7;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLR = 4'h9;
  localparam logic [3:0] MODE_PULSE = 4'hA;
  localparam logic [3:0] MODE_PULSE_CLR = 4'hB;
  localparam logic [3:0] MODE_PWM = 4'hF;

  // highest defined capture source code
  localparam logic [3:0] CAPSEL_MAX = 4'h8;
  // last count of the edge prescalers
  localparam logic [3:0] PRESC_4_LAST = 4'h3;
  localparam logic [3:0] PRESC_16_LAST = 4'hF;

  // values after reset
  localparam logic [7:0] VALUE_RST = 8'h00;
  localparam logic [3:0] CAPSEL_RST = 4'h0;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [7:0] TMAP_RST = 8'h55;
  localparam logic [9:0] DUTY_RST = 10'h000;
  localparam logic [3:0] CNT_RST = 4'h0;

  // per unit state
  typedef struct packed {
    logic on;            // module_on
    logic fmt;           // width_alignment
    logic [3:0] mode;    // function_select
    logic out;           // output_level
    logic [3:0] capsel;  // capture_source_select
    logic [7:0] lo;      // value_low_byte
    logic [7:0] hi;      // value_high_byte
    logic [9:0] duty;    // internal duty buffer
    logic [3:0] cnt;     // capture edge prescaler
    logic cap_prev;      // last capture input sample
    logic match_prev;    // last compare match
    logic pulse;         // pulse 0-1-0 in progress
  } ccp_unit_t;

  // whole block state
  typedef struct packed {
    ccp_unit_t [NUM_UNITS-1:0] unit;
    logic [7:0] tmap;             // timer_choice fields
    logic ack;                    // wishbone acknowledge
    logic [31:0] rdata;           // read data
    logic [NUM_UNITS-1:0] evt;    // event_flag pulses
    logic [3:0] clr;              // capture timer clear pulses
    logic adc;                    // conversion start pulse
  } ccp_state_t;

endpackage

/* File: logic/ccp_top.sv */
// Purpose: register layer and mode logic of four capture/compare/pwm units
// Assumes: all side inputs synchronous to clk_i; timers live outside
// Notes: capture timers 0,1,3,5 and period timers 2,4,6 are ports
//
// Overview of operation
// - pwm timing follows the system clock
// - reset restores registers, pins become inputs
// - bit 7 enables unit, bit 6 zero
// - bit 5 shows output, read-only
// - bit 4 picks pwm alignment only
// - code 1111 pwm, 1100-1110 reserved
// - 1011 pulse and clear, 1010 pulse
// - 1001 drives low, 1000 drives high
// - capture codes 0011 to 0111 edges
// - 0010 toggles, 0001 toggles and clears
// - code 0000 turns off and resets
// - events set flag and start conversion
// - capture source select, upper bits zero
// - low byte captures or compares low
// - high byte captures or compares high
// - right aligned width layout
// - left aligned width layout
// - two timer_choice bits per unit
// - timer_choice code selects timers
// - duty buffer loads on period match
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module ccp_top #(
  parameter int AW = 8  // wishbone byte address width
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // capture timer values: timer0, timer1, timer3, timer5
  input wire logic [3:0][15:0] capture_timer_i,
  // period timer time base and match: timer2, timer4, timer6
  input wire logic [2:0][9:0] period_base_i,
  input wire logic [2:0] period_match_i,
  // capture sources
  input wire logic [ccp_pkg::NUM_UNITS-1:0] remap_pin_i,
  input wire logic [1:0] comparator_output_i,
  input wire logic oscillator_input_i,
  input wire logic pin_change_event_i,
  input wire logic [3:0] logic_cell_output_i,
  // converter trigger routing
  input wire logic adc_trigger_en_i,
  input wire logic [1:0] adc_trigger_unit_i,
  // unit outputs
  output logic [ccp_pkg::NUM_UNITS-1:0] pin_o,
  output logic [ccp_pkg::NUM_UNITS-1:0] pin_oe_o,
  output logic [ccp_pkg::NUM_UNITS-1:0] event_flag_o,
  output logic [3:0] clear_timer_o,
  output logic adc_start_o
);

  // current and next state
  ccp_pkg::ccp_state_t q;
  ccp_pkg::ccp_state_t d;

  // capture source mux; reserved codes read as low
  function automatic logic cap_source(
    input logic [3:0] sel,
    input logic pin,
    input logic [1:0] cmp,
    input logic osc,
    input logic ioc,
    input logic [3:0] lc
  );
    logic r;
    r = 1'b0;
    unique case (sel)
      4'h0: r = pin;
      4'h1: r = cmp[0];
      4'h2: r = cmp[1];
      4'h3: r = osc;
      4'h4: r = ioc;
      4'h5: r = lc[0];
      4'h6: r = lc[1];
      4'h7: r = lc[2];
      4'h8: r = lc[3];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // period timer index for a timer_choice code
  function automatic logic [1:0] period_index(input logic [1:0] tsel);
    logic [1:0] r;
    r = 2'h0;
    unique case (tsel)
      2'h0: r = 2'h0; // timer2
      2'h1: r = 2'h0; // timer2
      2'h2: r = 2'h1; // timer4
      2'h3: r = 2'h2; // timer6
    endcase
    return r;
  endfunction

  // compare modes drive the pin from the match logic
  function automatic logic is_compare(input logic [3:0] m);
    return (m == ccp_pkg::MODE_TGL_CLR) || (m == ccp_pkg::MODE_TGL) ||
           ((m >= ccp_pkg::MODE_SET) && (m <= ccp_pkg::MODE_PULSE_CLR));
  endfunction

  // capture modes sample the timer on input edges
  function automatic logic is_capture(input logic [3:0] m);
    return (m >= ccp_pkg::MODE_CAP_ANY) && (m <= ccp_pkg::MODE_CAP_16);
  endfunction

  // next state: bus access, then unit logic per unit
  always_comb begin
    logic req;
    logic [5:0] word;
    logic [1:0] uidx;
    logic [1:0] ridx;
    logic hit_unit;
    logic hit_tmap;
    logic [31:0] rd;
    logic [1:0] tsel;
    logic [1:0] pidx;
    logic [15:0] ct;
    logic cin;
    logic rise;
    logic fall;
    logic take;
    logic match;
    logic [9:0] width;
    ccp_pkg::ccp_unit_t u;
    req = 1'b0;
    word = 6'h00;
    uidx = 2'h0;
    ridx = 2'h0;
    hit_unit = 1'b0;
    hit_tmap = 1'b0;
    rd = 32'h0000_0000;
    tsel = 2'h0;
    pidx = 2'h0;
    ct = 16'h0000;
    cin = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    take = 1'b0;
    match = 1'b0;
    width = 10'h000;
    u = q.unit[0];
    d = q;
    // event, clear and conversion outputs are one-cycle pulses
    d.evt = '0;
    d.clr = '0;
    d.adc = 1'b0;

    // single cycle answer; ack drops in the cycle after it was given
    req = wb_cyc_i && wb_stb_i && !q.ack;
    d.ack = req;
    word = wb_adr_i[7:2];
    // unit windows are 16 bytes apart, so address bits 5:4 pick the unit
    uidx = word[3:2];
    ridx = word[1:0];
    hit_unit = (wb_adr_i[AW-1:6] == '0);
    hit_tmap = (wb_adr_i[7:0] == ccp_pkg::OFF_TMAP);

    // read mux; unmapped words answer zero
    if (hit_unit) begin
      u = q.unit[uidx];
      unique case ({ridx, 2'b00})
        ccp_pkg::OFF_CONTROL[3:0]: begin
          rd[7:0] = {u.on, 1'b0, u.out, u.fmt, u.mode};
        end
        ccp_pkg::OFF_CAPSEL[3:0]: begin
          rd[7:0] = {4'h0, u.capsel};
        end
        ccp_pkg::OFF_LOW[3:0]: begin
          rd[7:0] = u.lo;
        end
        ccp_pkg::OFF_HIGH[3:0]: begin
          rd[7:0] = u.hi;
        end
        default: begin
          rd = 32'h0000_0000;
        end
      endcase
    end else if (hit_tmap) begin
      rd[7:0] = q.tmap;
    end
    if (req && !wb_we_i) begin
      d.rdata = rd;
    end

    // writes land on the edge that raises ack
    if (req && wb_we_i && wb_sel_i[0]) begin
      if (hit_unit) begin
        unique case ({ridx, 2'b00})
          ccp_pkg::OFF_CONTROL[3:0]: begin
            // output level and bit 6 ignore writes
            d.unit[uidx].on = wb_dat_i[ccp_pkg::BIT_ON];
            // alignment is stored in every mode but only read by pwm
            d.unit[uidx].fmt = wb_dat_i[ccp_pkg::BIT_FMT];
            d.unit[uidx].mode = wb_dat_i[3:0];
          end
          ccp_pkg::OFF_CAPSEL[3:0]: begin
            d.unit[uidx].capsel = wb_dat_i[3:0];
          end
          ccp_pkg::OFF_LOW[3:0]: begin
            d.unit[uidx].lo = wb_dat_i[7:0];
          end
          ccp_pkg::OFF_HIGH[3:0]: begin
            d.unit[uidx].hi = wb_dat_i[7:0];
          end
          default: begin
            d.unit[uidx].hi = q.unit[uidx].hi;
          end
        endcase
      end else if (hit_tmap) begin
        d.tmap = wb_dat_i[7:0];
      end
    end

    // unit logic; hardware capture wins over a same-cycle write
    for (int i = 0; i < ccp_pkg::NUM_UNITS; i++) begin
      u = q.unit[i];
      tsel = q.tmap[2*i +: 2];
      pidx = period_index(tsel);
      ct = capture_timer_i[tsel];
      cin = cap_source(u.capsel, remap_pin_i[i], comparator_output_i,
                       oscillator_input_i, pin_change_event_i,
                       logic_cell_output_i);
      rise = cin && !u.cap_prev;
      fall = !cin && u.cap_prev;
      match = (ct == {u.hi, u.lo});
      d.unit[i].cap_prev = cin;
      // width layout by alignment bit
      if (u.fmt) begin
        width = {u.hi, u.lo[7:6]};
      end else begin
        width = {u.hi[1:0], u.lo};
      end

      if (u.mode == ccp_pkg::MODE_OFF) begin
        // off: internal state back to idle
        d.unit[i].out = 1'b0;
        d.unit[i].cnt = ccp_pkg::CNT_RST;
        d.unit[i].pulse = 1'b0;
        d.unit[i].match_prev = 1'b0;
      end else if (!u.on) begin
        // disabled: hold state but clear match memory, no events
        d.unit[i].match_prev = 1'b0;
      end else if (is_capture(u.mode)) begin
        take = 1'b0;
        unique case (u.mode)
          ccp_pkg::MODE_CAP_ANY: take = rise || fall;
          ccp_pkg::MODE_CAP_FALL: take = fall;
          ccp_pkg::MODE_CAP_RISE: take = rise;
          ccp_pkg::MODE_CAP_4: begin
            take = rise && (u.cnt >= ccp_pkg::PRESC_4_LAST);
          end
          ccp_pkg::MODE_CAP_16: begin
            take = rise && (u.cnt == ccp_pkg::PRESC_16_LAST);
          end
          default: take = 1'b0;
        endcase
        // prescaler counts rising edges, restarts after a capture
        if (take) begin
          d.unit[i].cnt = ccp_pkg::CNT_RST;
        end else if (rise) begin
          d.unit[i].cnt = u.cnt + 4'h1;
        end
        if (take) begin
          d.unit[i].lo = ct[7:0];
          d.unit[i].hi = ct[15:8];
          // flag pulse is the unit's event for software and converter
          d.evt[i] = 1'b1;
        end
      end else if (is_compare(u.mode)) begin
        // act once on the first cycle of a match
        d.unit[i].match_prev = match;
        if (u.pulse) begin
          d.unit[i].out = 1'b0;
          d.unit[i].pulse = 1'b0;
        end
        if (match && !u.match_prev) begin
          // a match held over several cycles raises one event only
          d.evt[i] = 1'b1;
          unique case (u.mode)
            ccp_pkg::MODE_SET: d.unit[i].out = 1'b1;
            ccp_pkg::MODE_CLR: d.unit[i].out = 1'b0;
            ccp_pkg::MODE_PULSE: begin
              d.unit[i].out = 1'b1;
              d.unit[i].pulse = 1'b1;
            end
            ccp_pkg::MODE_PULSE_CLR: begin
              d.unit[i].out = 1'b1;
              d.unit[i].pulse = 1'b1;
              d.clr[tsel] = 1'b1;
            end
            ccp_pkg::MODE_TGL: d.unit[i].out = !u.out;
            ccp_pkg::MODE_TGL_CLR: begin
              d.unit[i].out = !u.out;
              d.clr[tsel] = 1'b1;
            end
            default: d.unit[i].out = u.out;
          endcase
        end
      end else if (u.mode == ccp_pkg::MODE_PWM) begin
        // time base counts system clocks, so rate tracks the clock
        if (period_match_i[pidx]) begin
          d.unit[i].duty = width;
          d.unit[i].out = (width != 10'h000);
          // period start counts as the pwm event
          d.evt[i] = 1'b1;
        end else if (period_base_i[pidx] == u.duty) begin
          d.unit[i].out = 1'b0;
        end
      end
      // reserved codes 1100-1110 leave the unit idle
    end

    // converter start follows the chosen unit's event
    d.adc = adc_trigger_en_i && d.evt[adc_trigger_unit_i];
  end

  // state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ccp_pkg::NUM_UNITS; i++) begin
        q.unit[i].on <= 1'b0;
        q.unit[i].fmt <= 1'b0;
        q.unit[i].mode <= ccp_pkg::MODE_RST;
        q.unit[i].out <= 1'b0;
        q.unit[i].capsel <= ccp_pkg::CAPSEL_RST;
        q.unit[i].lo <= ccp_pkg::VALUE_RST;
        q.unit[i].hi <= ccp_pkg::VALUE_RST;
        q.unit[i].duty <= ccp_pkg::DUTY_RST;
        q.unit[i].cnt <= ccp_pkg::CNT_RST;
        q.unit[i].cap_prev <= 1'b0;
        q.unit[i].match_prev <= 1'b0;
        q.unit[i].pulse <= 1'b0;
      end
      q.tmap <= ccp_pkg::TMAP_RST;
      q.ack <= 1'b0;
      q.rdata <= 32'h0000_0000;
      // no pulse survives a reset
      q.evt <= '0;
      q.clr <= 4'h0;
      q.adc <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;
  assign event_flag_o = q.evt;
  assign clear_timer_o = q.clr;
  assign adc_start_o = q.adc;

  // pin drive only in enabled compare or pwm modes
  for (genvar g = 0; g < ccp_pkg::NUM_UNITS; g++) begin : g_pin
    assign pin_o[g] = q.unit[g].out;
    assign pin_oe_o[g] = q.unit[g].on &&
        (is_compare(q.unit[g].mode) ||
         (q.unit[g].mode == ccp_pkg::MODE_PWM));
  end

endmodule

/* File: test/ccp_checker.sv */
// Purpose: port level checks of the capture/compare/pwm block
// Assumes: one clock, synchronous active high reset
// Notes: bound to the top module below
`timescale 1ns/10ps
module ccp_checker #(
  parameter int AW = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic adc_trigger_en_i,
  input wire logic [1:0] adc_trigger_unit_i,
  input wire logic [ccp_pkg::NUM_UNITS-1:0] pin_o,
  input wire logic [ccp_pkg::NUM_UNITS-1:0] pin_oe_o,
  input wire logic [ccp_pkg::NUM_UNITS-1:0] event_flag_o,
  input wire logic [3:0] clear_timer_o,
  input wire logic adc_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request left without ack");
  ack_cause_a: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  unmapped_zero_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i == AW'(8'h50) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  reset_idle_a: assert property ($fell(rst_i) |-> pin_o == 4'h0
    && pin_oe_o == 4'h0 && event_flag_o == 4'h0)
    else $error("outputs not idle after reset");
  adc_source_a: assert property (
    adc_start_o |-> $past(adc_trigger_en_i)
    && event_flag_o[$past(adc_trigger_unit_i)])
    else $error("conversion start without unit event");
  clear_event_a: assert property (
    |clear_timer_o |-> |event_flag_o)
    else $error("timer clear without event");
endmodule
bind ccp_top ccp_checker #(.AW(AW)) i_ccp_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .adc_trigger_en_i(adc_trigger_en_i),
  .adc_trigger_unit_i(adc_trigger_unit_i), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o), .event_flag_o(event_flag_o),
  .clear_timer_o(clear_timer_o), .adc_start_o(adc_start_o));

/* File: test/ccp_timer_model.sv */
// Purpose: timer side model for the capture/compare/pwm block
// Assumes: one free counter stands in for all capture timers
// Notes: period base wraps at PER and pulses match at its top
`timescale 1ns/10ps
module ccp_timer_model #(
  parameter int PER = 255  // period register value, plain default
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hold_i,  // freeze the capture count
  input wire logic [3:0] clear_timer_i,
  output logic [15:0] count_o,
  output logic [3:0][15:0] capture_timer_o,
  output logic [2:0][9:0] period_base_o,
  output logic [2:0] period_match_o
);
  logic [9:0] base_q;  // shared pwm time base
  // capture count; any clear request restarts it
  always_ff @(posedge clk_i) begin
    if (rst_i || |clear_timer_i) begin
      count_o <= 16'h0000;
    end else if (!hold_i) begin
      count_o <= count_o + 16'h0001;
    end
  end
  // time base steps on every system clock
  always_ff @(posedge clk_i) begin
    if (rst_i || base_q == 10'(PER)) begin
      base_q <= 10'h000;
    end else begin
      base_q <= base_q + 10'h001;
    end
  end
  assign capture_timer_o = {4{count_o}};
  assign period_base_o = {3{base_q}};
  assign period_match_o = {3{base_q == 10'(PER)}};
endmodule

/* File: test/test_ccp_control_registers.sv */
// Purpose: self-checking bench of the capture/compare/pwm block
// Assumes: timer model supplies capture counts and period matches
// Notes: scenarios after the register checks use unit 0, whose timer code stays 01
`timescale 1ns/10ps
module test_ccp_control_registers;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [8:0] src = 9'h000;  // one bit per capture source code
  logic hold = 1'b0;  // freezes the capture count
  logic adc_en = 1'b0;
  logic [31:0] rd, dat_o;
  logic ack, adc, ev0, pin0;
  logic [3:0][15:0] ct;
  logic [2:0][9:0] pb;
  logic [2:0] pm;
  logic [15:0] cnt;
  logic [3:0] pin, oe, evf, clr;
  int failures = 0;
  int check_count = 0;
  assign ev0 = evf[0];
  assign pin0 = pin[0];
  always #12.5 clk_i = ~clk_i;
  ccp_top i_ccp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .capture_timer_i(ct), .period_base_i(pb), .period_match_i(pm),
    .remap_pin_i({3'h0, src[0]}), .comparator_output_i(src[2:1]),
    .oscillator_input_i(src[3]), .pin_change_event_i(src[4]),
    .logic_cell_output_i(src[8:5]), .adc_trigger_en_i(adc_en),
    .adc_trigger_unit_i(2'h0), .pin_o(pin), .pin_oe_o(oe),
    .event_flag_o(evf), .clear_timer_o(clr), .adc_start_o(adc));
  ccp_timer_model i_ccp_timer_model (.clk_i(clk_i), .rst_i(rst_i),
    .hold_i(hold), .clear_timer_i(clr), .count_o(cnt),
    .capture_timer_o(ct), .period_base_o(pb), .period_match_o(pm));
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(nm, {24'h0, e}, rd);
  endtask
  // bounded wait for a level of unit 0 event or pin; running out fails
  task automatic wait_lvl(input logic on_pin, input logic v);
    int n;
    logic s;
    n = 0;
    s = on_pin ? pin0 : ev0;
    while (s !== v && n < 1000) begin
      @(posedge clk_i);
      n++;
      s = on_pin ? pin0 : ev0;
    end
    if (s !== v) begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic t_regs();
    check("pin enables", 32'h0, {28'h0, oe});
    rdchk("timer map", 8'h40, 8'h55);
    bus(1'b1, 8'h00, 8'h70);
    rdchk("control", 8'h00, 8'h10);
    bus(1'b1, 8'h04, 8'hFF);
    rdchk("source select", 8'h04, 8'h0F);
    bus(1'b1, 8'h18, 8'hA5);
    rdchk("low byte", 8'h18, 8'hA5);
    rdchk("unit 0 low", 8'h08, 8'h00);
    bus(1'b1, 8'h1C, 8'h3C);
    rdchk("high byte", 8'h1C, 8'h3C);
    bus(1'b1, 8'h40, 8'hE4);
    rdchk("timer map", 8'h40, 8'hE4);
    bus(1'b1, 8'h40, 8'h55);
    bus(1'b1, 8'h04, 8'h00);
    rdchk("unmapped", 8'h50, 8'h00);
  endtask
  // each compare mode in turn, timer frozen while set up
  task automatic t_compare();
    logic [7:0] md [6] = '{8'h88, 8'h89, 8'h82, 8'h81, 8'h8A, 8'h8B};
    logic [1:0] ep [6] = '{2'b11, 2'b00, 2'b11, 2'b00, 2'b10, 2'b10};
    logic [15:0] cmp;
    logic [31:0] ec;
    adc_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      hold <= 1'b1;
      cmp = cnt + 16'h0020;
      ec = (md[i] == 8'h81 || md[i] == 8'h8B) ? 32'h2 : 32'h0;
      bus(1'b1, 8'h08, cmp[7:0]);
      bus(1'b1, 8'h0C, cmp[15:8]);
      bus(1'b1, 8'h00, md[i]);
      hold <= 1'b0;
      wait_lvl(1'b0, 1'b1);
      check("pin at match", {31'h0, ep[i][1]}, {31'h0, pin0});
      check("conversion start", 32'h1, {31'h0, adc});
      check("timer clear", ec, {28'h0, clr});
      @(posedge clk_i);
      check("pin after", {31'h0, ep[i][0]}, {31'h0, pin0});
    end
  endtask
  // every capture source in turn, rising edge mode
  task automatic t_capture();
    logic [15:0] v;
    bus(1'b1, 8'h00, 8'h85);
    for (int s = 0; s < 9; s++) begin
      bus(1'b1, 8'h04, 8'(s));
      hold <= 1'b1;
      @(posedge clk_i);
      src <= 9'h001 << s;
      wait_lvl(1'b0, 1'b1);
      v = cnt;
      src <= 9'h000;
      hold <= 1'b0;
      rdchk("captured low", 8'h08, v[7:0]);
      rdchk("captured high", 8'h0C, v[15:8]);
    end
  endtask
  // count capture events over 16 pulses for each edge mode
  task automatic t_prescale();
    logic [7:0] md [5] = '{8'h85, 8'h84, 8'h83, 8'h86, 8'h87};
    int ex [5] = '{16, 16, 32, 4, 1};
    int n;
    bus(1'b1, 8'h04, 8'h00);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 8'h00, 8'h80);
      bus(1'b1, 8'h00, md[i]);
      n = 0;
      for (int k = 0; k < 36; k++) begin
        @(posedge clk_i);
        if (k < 32) src[0] <= ~src[0];
        if (ev0 === 1'b1) n++;
      end
      check("capture events", ex[i], n);
    end
  endtask
  // pwm high time ends when the time base passes the width
  task automatic t_pwm();
    logic [7:0] lo [2] = '{8'h30, 8'h40};
    logic [7:0] hi [2] = '{8'h00, 8'h0C};
    logic [9:0] dt [2] = '{10'h031, 10'h032};
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 8'h08, lo[i]);
      bus(1'b1, 8'h0C, hi[i]);
      bus(1'b1, 8'h00, i ? 8'h9F : 8'h8F);
      wait_lvl(1'b1, 1'b0);
      wait_lvl(1'b1, 1'b1);
      wait_lvl(1'b1, 1'b0);
      check("width end", 32'(dt[i]), 32'(pb[0]));
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_compare();
    t_capture();
    t_prescale();
    t_pwm();
    report_and_stop();
  end
endmodule
